/* common/t16co_pkg.sv */
// shared constants and types of the 16-bit timer compare-output block
package t16co_pkg;

   // ------------------------------------------------------------------
   // bus widths and channel count
   // ------------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int CHAN_N = 3;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [3:0] ADDR_WAVE_CTRL = 4'h0;
   localparam logic [3:0] ADDR_WAVE_HIGH = 4'h1;
   localparam logic [3:0] ADDR_CMP_A = 4'h2;
   localparam logic [3:0] ADDR_CMP_B = 4'h3;
   localparam logic [3:0] ADDR_CMP_C = 4'h4;
   localparam logic [3:0] ADDR_TOP_VALUE = 4'h5;
   localparam logic [3:0] ADDR_COUNT = 4'h6;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int CHA_MODE_LSB = 6;
   localparam int CHB_MODE_LSB = 4;
   localparam int CHC_MODE_LSB = 2;
   localparam int WM_LO_LSB = 0;
   localparam int WM_HI_LSB = 0;
   localparam int IRQ_MATCH_A = 0;
   localparam int IRQ_MATCH_B = 1;
   localparam int IRQ_MATCH_C = 2;
   localparam int IRQ_OVERFLOW = 3;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] WAVE_CTRL_RST = 8'h00;
   localparam logic [1:0] WAVE_HIGH_RST = 2'h0;
   localparam logic [15:0] CMP_RST = 16'h0000;
   localparam logic [15:0] TOP_VALUE_RST = 16'h0000;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [3:0] IRQ_RST = 4'h0;

   // ------------------------------------------------------------------
   // counter limits and waveform modes
   // ------------------------------------------------------------------
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   localparam logic [15:0] TOP_MAX = 16'hFFFF;
   localparam logic [3:0] WM_PFC_CMPA = 4'h9;
   localparam logic [3:0] WM_PC_CMPA = 4'hB;
   localparam logic [3:0] WM_FAST_CMPA = 4'hF;

   localparam logic [1:0] OM_OFF = 2'h0;
   localparam logic [1:0] OM_TOGGLE = 2'h1;
   localparam logic [1:0] OM_CLEAR = 2'h2;
   localparam logic [1:0] OM_SET = 2'h3;

   typedef enum logic [2:0] {
      KIND_NONPWM = 3'b001,
      KIND_FAST = 3'b010,
      KIND_DUAL = 3'b100
   } t16co_kind_type;

   typedef enum logic [1:0] {
      DIR_UP = 2'b01,
      DIR_DOWN = 2'b10
   } t16co_dir_type;

endpackage : t16co_pkg

/* core/t16co_chan.sv */
// one compare-output channel: waveform level and pin override
`timescale 1ns/100ps
module t16co_chan (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // timing events
   input wire logic tick,
   input wire logic match,
   input wire logic wrap_bottom,
   input wire logic counting_up,
   input wire logic cmp_is_top,
   // configuration
   input wire t16co_pkg::t16co_kind_type kind,
   input wire logic [1:0] mode,
   input wire logic toggle_ok,
   // pin side
   output logic level_r,
   output logic drive_r
);

   logic level_nxt;
   logic drive_nxt;

   // ------------------------------------------------------------------
   // next level
   // ------------------------------------------------------------------
   always_comb begin
      level_nxt = level_r;
      drive_nxt = (mode != t16co_pkg::OM_OFF) &&  // R05
         !(mode == t16co_pkg::OM_TOGGLE && !toggle_ok);  // R08 R12
      case (kind)
         t16co_pkg::KIND_NONPWM: begin
            if (tick && match) begin  // R18
               case (mode)  // R07
                  t16co_pkg::OM_TOGGLE: level_nxt = !level_r;
                  t16co_pkg::OM_CLEAR: level_nxt = 1'b0;
                  t16co_pkg::OM_SET: level_nxt = 1'b1;
                  default: level_nxt = level_r;
               endcase
            end
         end
         t16co_pkg::KIND_FAST: begin
            // bottom handling wins, so a match at TOP cannot undo it
            if (tick && wrap_bottom && mode[1]) begin
               level_nxt = (mode == t16co_pkg::OM_CLEAR);  // R09 R10
            end else if (tick && match && !(cmp_is_top && mode[1])) begin
               case (mode)  // R11
                  t16co_pkg::OM_TOGGLE: level_nxt = toggle_ok ? !level_r
                     : level_r;  // R08
                  t16co_pkg::OM_CLEAR: level_nxt = 1'b0;  // R09
                  t16co_pkg::OM_SET: level_nxt = 1'b1;  // R10
                  default: level_nxt = level_r;
               endcase
            end
         end
         t16co_pkg::KIND_DUAL: begin
            if (tick && match) begin
               case (mode)
                  t16co_pkg::OM_TOGGLE: level_nxt = toggle_ok ? !level_r
                     : level_r;  // R12
                  t16co_pkg::OM_CLEAR: level_nxt = !counting_up;  // R13
                  t16co_pkg::OM_SET: level_nxt = counting_up;  // R14
                  default: level_nxt = level_r;
               endcase
            end
         end
         default: level_nxt = level_r;
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         level_r <= 1'b0;
         drive_r <= 1'b0;
      end else begin
         level_r <= level_nxt;
         drive_r <= drive_nxt;
      end
   end

endmodule : t16co_chan

/* core/t16co_top.sv */
// 16-bit timer with three compare-output channels and register port
`timescale 1ns/100ps
// Function
// R01 - single clock, timer tick is enable
// R02 - buffer compare values only in buffered modes
// R03 - frequency-correct mode loads compares at BOTTOM
// R04 - control register channel and mode fields
// R05 - nonzero output mode drives the pin
// R06 - software sets pin direction to output
// R07 - non-PWM: off, toggle, clear, set
// R08 - fast PWM toggle only channel A mode 15
// R09 - fast non-inverting: clear match, set BOTTOM
// R10 - fast inverting: set match, clear BOTTOM
// R11 - fast PWM ignores match when compare equals TOP; code ignores it only in output modes 2 and 3, toggle still acts
// R12 - dual-slope toggle only channel A modes 9/11
// R13 - dual-slope mode 2: clear up, set down
// R14 - dual-slope mode 3: set up, clear down
// R15 - four-bit mode picks sequence, TOP, waveform
// R16 - dual-slope counts BOTTOM to TOP and back
// R17 - match flag set on compare equality
// R18 - events act only on timer ticks
module t16co_top (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // prescaled timer tick, same clock domain
   input wire logic timer_clock_enable,
   // register port
   input wire logic [t16co_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [t16co_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [t16co_pkg::DATA_W-1:0] reg_rdata,
   // compare outputs and their pin overrides
   output logic chan_a_compare_out,
   output logic chan_a_compare_oe,
   output logic chan_b_compare_out,
   output logic chan_b_compare_oe,
   output logic chan_c_compare_out,
   output logic chan_c_compare_oe,
   // counter state and interrupt
   output logic [15:0] counter_value,
   output logic irq
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic [7:0] wave_ctrl_r;
   logic [7:0] wave_ctrl_nxt;
   logic [1:0] wave_high_r;
   logic [1:0] wave_high_nxt;
   logic [15:0] top_value_r;
   logic [15:0] top_value_nxt;
   logic [3:0] irq_stat_r;
   logic [3:0] irq_stat_nxt;
   logic [3:0] irq_mask_r;
   logic [3:0] irq_mask_nxt;
   logic irq_r;
   logic irq_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   t16co_pkg::t16co_dir_type dir_r;
   t16co_pkg::t16co_dir_type dir_nxt;

   logic [3:0] wmode;
   t16co_pkg::t16co_kind_type kind;
   logic [15:0] top_lim;
   logic at_top;
   logic at_bottom;
   logic load_evt;
   logic ovf_evt;
   logic [15:0] cmp_act [t16co_pkg::CHAN_N];
   logic [15:0] cmp_buf [t16co_pkg::CHAN_N];
   logic [t16co_pkg::CHAN_N-1:0] match;
   logic [t16co_pkg::CHAN_N-1:0] level;
   logic [t16co_pkg::CHAN_N-1:0] drive;

   // ------------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------------
   assign wmode = {wave_high_r[t16co_pkg::WM_HI_LSB +: 2],
                   wave_ctrl_r[t16co_pkg::WM_LO_LSB +: 2]};  // R04

   always_comb begin
      kind = t16co_pkg::KIND_NONPWM;
      top_lim = t16co_pkg::TOP_MAX;
      case (wmode)  // R15
         4'h0: top_lim = t16co_pkg::TOP_MAX;
         4'h1: begin
            kind = t16co_pkg::KIND_DUAL;
            top_lim = t16co_pkg::TOP_8BIT;
         end
         4'h2: begin
            kind = t16co_pkg::KIND_DUAL;
            top_lim = t16co_pkg::TOP_9BIT;
         end
         4'h3: begin
            kind = t16co_pkg::KIND_DUAL;
            top_lim = t16co_pkg::TOP_10BIT;
         end
         4'h4: top_lim = cmp_act[0];
         4'h5: begin
            kind = t16co_pkg::KIND_FAST;
            top_lim = t16co_pkg::TOP_8BIT;
         end
         4'h6: begin
            kind = t16co_pkg::KIND_FAST;
            top_lim = t16co_pkg::TOP_9BIT;
         end
         4'h7: begin
            kind = t16co_pkg::KIND_FAST;
            top_lim = t16co_pkg::TOP_10BIT;
         end
         4'h8, 4'hA: begin
            kind = t16co_pkg::KIND_DUAL;
            top_lim = top_value_r;
         end
         4'h9, 4'hB: begin
            kind = t16co_pkg::KIND_DUAL;
            top_lim = cmp_act[0];
         end
         4'hC: top_lim = top_value_r;
         4'hE: begin
            kind = t16co_pkg::KIND_FAST;
            top_lim = top_value_r;
         end
         4'hF: begin
            kind = t16co_pkg::KIND_FAST;
            top_lim = cmp_act[0];
         end
         // reserved mode behaves as a free-running normal counter
         default: top_lim = t16co_pkg::TOP_MAX;
      endcase
   end

   assign at_top = (count_r == top_lim);
   assign at_bottom = (count_r == t16co_pkg::BOTTOM);

   // ------------------------------------------------------------------
   // compare buffer load point
   // ------------------------------------------------------------------
   always_comb begin
      load_evt = 1'b0;
      ovf_evt = 1'b0;
      case (kind)
         t16co_pkg::KIND_NONPWM: begin
            ovf_evt = timer_clock_enable &&
               (count_r == t16co_pkg::TOP_MAX);
         end
         t16co_pkg::KIND_FAST: begin
            // the wrap from TOP is the arrival at BOTTOM
            load_evt = timer_clock_enable && at_top;
            ovf_evt = timer_clock_enable && at_top;
         end
         t16co_pkg::KIND_DUAL: begin
            if (wmode[3:1] == 3'h4) begin
               load_evt = timer_clock_enable && at_bottom;  // R03
            end else begin
               load_evt = timer_clock_enable && at_top;
            end
            ovf_evt = timer_clock_enable && at_bottom &&
               (dir_r == t16co_pkg::DIR_DOWN);
         end
         default: load_evt = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // counter
   // ------------------------------------------------------------------
   always_comb begin
      count_nxt = count_r;
      dir_nxt = dir_r;
      if (timer_clock_enable) begin  // R01
         if (kind == t16co_pkg::KIND_DUAL) begin
            case (dir_r)  // R16
               t16co_pkg::DIR_UP: begin
                  if (at_top) begin
                     dir_nxt = t16co_pkg::DIR_DOWN;
                     count_nxt = at_bottom ? count_r : count_r - 16'h0001;
                  end else begin
                     count_nxt = count_r + 16'h0001;
                  end
               end
               t16co_pkg::DIR_DOWN: begin
                  if (at_bottom) begin
                     dir_nxt = t16co_pkg::DIR_UP;
                     count_nxt = at_top ? count_r : count_r + 16'h0001;
                  end else begin
                     count_nxt = count_r - 16'h0001;
                  end
               end
               default: begin
                  dir_nxt = t16co_pkg::DIR_UP;
                  count_nxt = t16co_pkg::BOTTOM;
               end
            endcase
         end else begin
            dir_nxt = t16co_pkg::DIR_UP;
            count_nxt = at_top ? t16co_pkg::BOTTOM : count_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= t16co_pkg::COUNT_RST;
         dir_r <= t16co_pkg::DIR_UP;
      end else begin
         count_r <= count_nxt;
         dir_r <= dir_nxt;
      end
   end

   // ------------------------------------------------------------------
   // per-channel compare registers and waveform logic
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < t16co_pkg::CHAN_N; gi++) begin : g_chan
         logic [15:0] buf_r;
         logic [15:0] buf_nxt;
         logic [15:0] act_r;
         logic [15:0] act_nxt;
         logic wr_hit;
         logic toggle_ok;
         logic [1:0] mode;

         assign mode = wave_ctrl_r[t16co_pkg::CHA_MODE_LSB - 2*gi +: 2];
         assign wr_hit = reg_wr &&
            (reg_addr == t16co_pkg::ADDR_CMP_A + 4'(gi));

         always_comb begin
            buf_nxt = wr_hit ? reg_wdata : buf_r;
            act_nxt = act_r;
            if (kind == t16co_pkg::KIND_NONPWM) begin
               act_nxt = buf_nxt;  // R02
            end else if (load_evt) begin
               act_nxt = buf_r;  // R02
            end
         end

         always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
               buf_r <= t16co_pkg::CMP_RST;
               act_r <= t16co_pkg::CMP_RST;
            end else begin
               buf_r <= buf_nxt;
               act_r <= act_nxt;
            end
         end

         assign cmp_act[gi] = act_r;
         assign cmp_buf[gi] = buf_r;
         assign match[gi] = timer_clock_enable &&
            (count_r == act_r);  // R17 R18

         always_comb begin
            toggle_ok = 1'b1;
            if (kind == t16co_pkg::KIND_FAST) begin
               toggle_ok = (gi == 0) &&
                  (wmode == t16co_pkg::WM_FAST_CMPA);  // R08
            end else if (kind == t16co_pkg::KIND_DUAL) begin
               toggle_ok = (gi == 0) &&
                  ((wmode == t16co_pkg::WM_PFC_CMPA) ||
                   (wmode == t16co_pkg::WM_PC_CMPA));  // R12
            end
         end

         t16co_chan u_chan (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .tick(timer_clock_enable),
            .match(match[gi]),
            .wrap_bottom(at_top),
            .counting_up(dir_r == t16co_pkg::DIR_UP),
            .cmp_is_top(act_r == top_lim),
            .kind(kind),
            .mode(mode),
            .toggle_ok(toggle_ok),
            .level_r(level[gi]),
            .drive_r(drive[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // control registers, interrupt and read port
   // ------------------------------------------------------------------
   always_comb begin
      wave_ctrl_nxt = wave_ctrl_r;
      wave_high_nxt = wave_high_r;
      top_value_nxt = top_value_r;
      irq_mask_nxt = irq_mask_r;
      irq_stat_nxt = irq_stat_r;
      if (reg_wr) begin
         case (reg_addr)
            t16co_pkg::ADDR_WAVE_CTRL: wave_ctrl_nxt = reg_wdata[7:0];  // R04
            t16co_pkg::ADDR_WAVE_HIGH: wave_high_nxt = reg_wdata[1:0];
            t16co_pkg::ADDR_TOP_VALUE: top_value_nxt = reg_wdata;
            t16co_pkg::ADDR_IRQ_MASK: irq_mask_nxt = reg_wdata[3:0];
            t16co_pkg::ADDR_IRQ_STATUS:
               irq_stat_nxt = irq_stat_r & ~reg_wdata[3:0];
            default: irq_mask_nxt = irq_mask_r;
         endcase
      end
      // set after clear so a same-cycle event survives the clear
      irq_stat_nxt[t16co_pkg::IRQ_MATCH_A +: 3] =
         irq_stat_nxt[t16co_pkg::IRQ_MATCH_A +: 3] | match;  // R17
      if (ovf_evt) begin
         irq_stat_nxt[t16co_pkg::IRQ_OVERFLOW] = 1'b1;
      end
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
      rdata_nxt = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            t16co_pkg::ADDR_WAVE_CTRL: rdata_nxt = {8'h00, wave_ctrl_r};
            t16co_pkg::ADDR_WAVE_HIGH: rdata_nxt = {14'h0, wave_high_r};
            t16co_pkg::ADDR_CMP_A: rdata_nxt = cmp_buf[0];
            t16co_pkg::ADDR_CMP_B: rdata_nxt = cmp_buf[1];
            t16co_pkg::ADDR_CMP_C: rdata_nxt = cmp_buf[2];
            t16co_pkg::ADDR_TOP_VALUE: rdata_nxt = top_value_r;
            t16co_pkg::ADDR_COUNT: rdata_nxt = count_r;
            t16co_pkg::ADDR_IRQ_STATUS: rdata_nxt = {12'h000, irq_stat_r};
            t16co_pkg::ADDR_IRQ_MASK: rdata_nxt = {12'h000, irq_mask_r};
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wave_ctrl_r <= t16co_pkg::WAVE_CTRL_RST;
         wave_high_r <= t16co_pkg::WAVE_HIGH_RST;
         top_value_r <= t16co_pkg::TOP_VALUE_RST;
         irq_mask_r <= t16co_pkg::IRQ_RST;
         irq_stat_r <= t16co_pkg::IRQ_RST;
         irq_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else begin
         wave_ctrl_r <= wave_ctrl_nxt;
         wave_high_r <= wave_high_nxt;
         top_value_r <= top_value_nxt;
         irq_mask_r <= irq_mask_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_r <= irq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   // pin driver also needs the port direction bit set by software
   assign chan_a_compare_out = level[0];
   assign chan_a_compare_oe = drive[0];
   assign chan_b_compare_out = level[1];
   assign chan_b_compare_oe = drive[1];
   assign chan_c_compare_out = level[2];
   assign chan_c_compare_oe = drive[2];
   assign counter_value = count_r;
   assign irq = irq_r;
   assign reg_rdata = rdata_r;

endmodule : t16co_top

/* test/t16co_assertions.sv */
// assertion checker for the timer compare-output block
`timescale 1ns/100ps
module t16co_assertions (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // timer tick and register port
   input wire logic timer_clock_enable,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // pin overrides and counter
   input wire logic chan_a_compare_oe,
   input wire logic chan_b_compare_oe,
   input wire logic chan_c_compare_oe,
   input wire logic [15:0] counter_value
);
   // ----------
   // shadow of the mode fields
   // ----------
   logic [7:0] ctl_r;
   logic [7:0] ctl_nxt;
   logic [1:0] hi_r;
   logic [1:0] hi_nxt;
   logic [1:0] quiet_r;
   logic [1:0] quiet_nxt;
   logic [3:0] wmode;
   assign wmode = {hi_r, ctl_r[1:0]};
   // override may lag a write by two cycles, so judge only when quiet
   always_comb begin
      ctl_nxt = ctl_r;
      hi_nxt = hi_r;
      quiet_nxt = (quiet_r == 2'h2) ? quiet_r : quiet_r + 2'h1;
      if (reg_wr && reg_addr == t16co_pkg::ADDR_WAVE_CTRL) begin
         ctl_nxt = reg_wdata[7:0];
         quiet_nxt = 2'h0;
      end
      if (reg_wr && reg_addr == t16co_pkg::ADDR_WAVE_HIGH) begin
         hi_nxt = reg_wdata[1:0];
         quiet_nxt = 2'h0;
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctl_r <= 8'h00;
         hi_r <= 2'h0;
         quiet_r <= 2'h0;
      end else begin
         ctl_r <= ctl_nxt;
         hi_r <= hi_nxt;
         quiet_r <= quiet_nxt;
      end
   end
   // toggle mode connects only where the waveform mode allows it
   function automatic logic oe_exp(logic [1:0] m, logic is_a,
                                   logic [3:0] w);
      if (m != 2'h1) return m != 2'h0;
      if (w inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF}) return is_a && w == 4'hF;
      if (w inside {[4'h1:4'h3], [4'h8:4'hB]})
         return is_a && (w == 4'h9 || w == 4'hB);
      return 1'b1;
   endfunction : oe_exp
   // ----------
   // assertions
   // ----------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_read(logic [3:0] a);
      reg_rd && reg_addr == a;
   endsequence
   a_rdata_idle:
      assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read reply");
   a_count_read:
      assert property (s_read(t16co_pkg::ADDR_COUNT) |=>
         reg_rdata == $past(counter_value))
      else $error("counter read does not match counter");
   a_ctrl_read:
      assert property (s_read(t16co_pkg::ADDR_WAVE_CTRL) |=>
         reg_rdata == {8'h00, $past(ctl_r)})
      else $error("control register read wrong");
   a_count_hold:
      assert property (!$past(timer_clock_enable) |-> $stable(counter_value))
      else $error("counter moved without a timer tick");
   a_count_step:
      assert property ($past(timer_clock_enable) |->
         counter_value == $past(counter_value) + 16'h0001 ||
         counter_value == $past(counter_value) - 16'h0001 ||
         counter_value == 16'h0000)
      else $error("counter step is not one");
   a_pin_a_drive:
      assert property (quiet_r == 2'h2 |->
         chan_a_compare_oe == oe_exp(ctl_r[7:6], 1'b1, wmode))
      else $error("channel a pin override wrong");
   a_pin_b_drive:
      assert property (quiet_r == 2'h2 |->
         chan_b_compare_oe == oe_exp(ctl_r[5:4], 1'b0, wmode))
      else $error("channel b pin override wrong");
   a_pin_c_drive:
      assert property (quiet_r == 2'h2 |->
         chan_c_compare_oe == oe_exp(ctl_r[3:2], 1'b0, wmode))
      else $error("channel c pin override wrong");
endmodule : t16co_assertions

bind t16co_top t16co_assertions chk_u (
   .ref_clk(ref_clk), .sys_rst(sys_rst),
   .timer_clock_enable(timer_clock_enable),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .chan_a_compare_oe(chan_a_compare_oe),
   .chan_b_compare_oe(chan_b_compare_oe),
   .chan_c_compare_oe(chan_c_compare_oe),
   .counter_value(counter_value)
);

/* test/tb_timer16_compare_output_control.sv */
// self-checking bench for the timer compare-output block
`timescale 1ns/100ps
module tb_timer16_compare_output_control;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic timer_clock_enable = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   wire logic [2:0] lvl;
   wire logic [2:0] oe;
   logic [15:0] counter_value;
   logic irq;
   int errors = 0;
   int n_checks = 0;

   t16co_top dut_u (
      .ref_clk(ref_clk), .sys_rst(sys_rst),
      .timer_clock_enable(timer_clock_enable),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .chan_a_compare_out(lvl[2]), .chan_a_compare_oe(oe[2]),
      .chan_b_compare_out(lvl[1]), .chan_b_compare_oe(oe[1]),
      .chan_c_compare_out(lvl[0]), .chan_c_compare_oe(oe[0]),
      .counter_value(counter_value), .irq(irq)
   );

   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   // ----------
   // bus, tick and compare tasks
   // ----------
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk_lvl(logic [2:0] exp);
      chk("levels a b c", {13'h0, exp}, {13'h0, lvl});
   endtask : chk_lvl
   task automatic chk_oe(logic [2:0] exp);
      chk("overrides a b c", {13'h0, exp}, {13'h0, oe});
   endtask : chk_oe
   task automatic do_reset();
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
   endtask : do_reset
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd_chk(logic [3:0] a, logic [15:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk("register read", exp, reg_rdata);
   endtask : rd_chk
   // ticks come two cycles apart so that gating by the enable shows
   task automatic tick(int n);
      repeat (n) begin
         @(posedge ref_clk);
         timer_clock_enable <= 1'b1;
         @(posedge ref_clk);
         timer_clock_enable <= 1'b0;
      end
      @(posedge ref_clk);
      #1;
   endtask : tick

   // ----------
   // scenarios
   // ----------
   task automatic t_regs();
      do_reset();
      for (int a = 0; a < 16; a++) rd_chk(a[3:0], 16'h0000);
      wr(t16co_pkg::ADDR_WAVE_CTRL, 16'hFFFF);
      rd_chk(t16co_pkg::ADDR_WAVE_CTRL, 16'h00FF);
      wr(t16co_pkg::ADDR_WAVE_HIGH, 16'hFFFF);
      rd_chk(t16co_pkg::ADDR_WAVE_HIGH, 16'h0003);
      wr(t16co_pkg::ADDR_COUNT, 16'h1234);
      wr(4'hC, 16'hFFFF);
      rd_chk(t16co_pkg::ADDR_COUNT, 16'h0000);
      rd_chk(4'hC, 16'h0000);
      chk_oe(3'b111);
   endtask : t_regs
   task automatic t_nonpwm();
      do_reset();
      wr(t16co_pkg::ADDR_CMP_A, 16'h0005);
      wr(t16co_pkg::ADDR_CMP_B, 16'h0005);
      wr(t16co_pkg::ADDR_CMP_C, 16'h0005);
      wr(t16co_pkg::ADDR_IRQ_MASK, 16'h0001);
      wr(t16co_pkg::ADDR_WAVE_HIGH, 16'h0001);
      wr(t16co_pkg::ADDR_WAVE_CTRL, 16'h007C);
      tick(5);
      chk("counter", 16'h0005, counter_value);
      chk_lvl(3'b000);
      tick(1);
      chk_lvl(3'b111);
      chk_oe(3'b111);
      rd_chk(t16co_pkg::ADDR_IRQ_STATUS, 16'h0007);
      chk("irq", 16'h0001, {15'h0, irq});
      wr(t16co_pkg::ADDR_IRQ_STATUS, 16'h0001);
      rd_chk(t16co_pkg::ADDR_IRQ_STATUS, 16'h0006);
      chk("irq", 16'h0000, {15'h0, irq});
      wr(t16co_pkg::ADDR_WAVE_CTRL, 16'h0068);
      tick(6);
      chk_lvl(3'b000);
   endtask : t_nonpwm
   task automatic t_fast();
      do_reset();
      wr(t16co_pkg::ADDR_CMP_A, 16'h0003);
      wr(t16co_pkg::ADDR_CMP_B, 16'h0003);
      wr(t16co_pkg::ADDR_CMP_C, 16'h0009);
      wr(t16co_pkg::ADDR_TOP_VALUE, 16'h0009);
      wr(t16co_pkg::ADDR_WAVE_HIGH, 16'h0003);
      wr(t16co_pkg::ADDR_WAVE_CTRL, 16'h00BA);
      tick(4);
      chk_lvl(3'b010);
      tick(6);
      chk_lvl(3'b101);
      tick(4);
      chk_lvl(3'b011);
      wr(t16co_pkg::ADDR_WAVE_CTRL, 16'h0052);
      rd_chk(t16co_pkg::ADDR_WAVE_CTRL, 16'h0052);
      chk_oe(3'b000);
      wr(t16co_pkg::ADDR_WAVE_CTRL, 16'h0053);
      rd_chk(t16co_pkg::ADDR_WAVE_CTRL, 16'h0053);
      chk_oe(3'b100);
      wr(t16co_pkg::ADDR_WAVE_HIGH, 16'h0002);
      tick(0);
      chk_oe(3'b100);
   endtask : t_fast
   task automatic t_dual();
      do_reset();
      wr(t16co_pkg::ADDR_CMP_A, 16'h0002);
      wr(t16co_pkg::ADDR_CMP_B, 16'h0002);
      wr(t16co_pkg::ADDR_CMP_C, 16'h0007);
      wr(t16co_pkg::ADDR_TOP_VALUE, 16'h0006);
      wr(t16co_pkg::ADDR_WAVE_CTRL, 16'h00B4);
      wr(t16co_pkg::ADDR_WAVE_HIGH, 16'h0002);
      tick(3);
      chk_lvl(3'b010);
      chk_oe(3'b110);
      tick(5);
      chk("counter", 16'h0004, counter_value);
      wr(t16co_pkg::ADDR_CMP_A, 16'h0004);
      tick(2);
      chk_lvl(3'b010);
      tick(1);
      chk_lvl(3'b100);
      tick(4);
      chk_lvl(3'b110);
      tick(2);
      chk_lvl(3'b010);
      rd_chk(t16co_pkg::ADDR_IRQ_STATUS, 16'h000B);
   endtask : t_dual

   // ----------
   // run control
   // ----------
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   initial begin
      t_regs();
      t_nonpwm();
      t_fast();
      t_dual();
      finish_test();
   end

   initial begin
      repeat (4000) @(posedge ref_clk);
      errors++;
      finish_test();
   end
endmodule : tb_timer16_compare_output_control
